//--- test/mcu_watchdog_timer_tb_top.sv
// self-checking bench for the watchdog core
`timescale 1ns/100ps
`default_nettype none
`include "mwdt_regs.svh"

module mcu_watchdog_timer_tb_top;
  logic        clk_in, srst, wr, rd, clr, halt, hold, force_on, sub_en, flash, wdt_rst, rc_on, rc_clk, sub_clk;
  logic [15:0] addr, boot, vec;
  logic [7:0]  wdata, rdata, cfg;
  logic [31:0] ticks, t0;
  int          err_total, comparisons, rst_seen, i;

  mwdt_top #(.SUB_LOSS_CYCLES(40)) mwdt_top_i (
    .clk_in(clk_in), .srst_in(srst), .ce_in(1'b1), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .clr_strobe_in(clr), .halt_in(halt),
    .hold_in(hold), .rc_force_on_in(force_on), .sub_osc_enable_in(sub_en), .rc_clk_in(rc_clk),
    .sub_clk_in(sub_clk), .flash_variant_in(flash), .boot_addr_opt_in(boot),
    .wdt_reset_out(wdt_rst), .rc_osc_on_out(rc_on), .restart_addr_out(vec));
  mwdt_osc_model mwdt_osc_model_i (.rc_on_in(rc_on), .sub_on_in(sub_en & ~hold),
    .rc_clk_out(rc_clk), .sub_clk_out(sub_clk), .rc_ticks_out(ticks));

  // ----------------------------------------------------------------------------
  // clock, monitor and helpers
  // ----------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // counts watchdog reset pulses
  always @(posedge clk_in) if (wdt_rst === 1'b1) rst_seen++;

  function automatic logic [31:0] near(input logic [31:0] d, input logic [31:0] e);
    return {31'h0, (d >= e) && (d <= e + 32'h2)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] d);
    @(posedge clk_in);
    addr  <= `MWDT_CTRL_ADDR;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, exp});
  endtask

  task automatic start(input logic [7:0] c);
    wr_reg(c);
    wr_reg(c | 8'h20);
  endtask

  task automatic wait_rst(input int max);
    int n;
    n = 0;
    while (wdt_rst !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > max) begin
        err_total++;
        $display("Error at %0t: wait ran out", $time);
        finish_test();
      end
    end
  endtask

  task automatic wait_ticks(input int n);
    logic [31:0] tgt;
    int          k;
    tgt = ticks + n;
    for (k = 0; k < 20 * n && ticks < tgt; k++) @(posedge clk_in);
    if (ticks < tgt) begin
      err_total++;
      $display("Error at %0t: tick wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic sysrst();
    @(posedge clk_in);
    srst <= 1'b1;
    hold <= 1'b0;
    repeat (4) @(posedge clk_in);
    srst <= 1'b0;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    {srst, wr, rd, clr, halt, hold, force_on, sub_en, flash} = 9'h100;
    {addr, boot, wdata} = 40'h0;
    err_total = 0;
    comparisons = 0;
    rst_seen = 0;
    void'($urandom(32'h19ed));
    repeat (10) @(posedge clk_in);
    srst <= 1'b0;
    rd_reg(`MWDT_CTRL_ADDR, 8'h00);
    rd_reg(16'hfe7a, 8'h00);
    // overflow length, write lock, flag and restart vector
    for (i = 0; i < 2; i++) begin
      cfg = {3'h0, ($urandom_range(1, 0) ? 2'h3 : 2'h0), 3'(i)};
      flash <= 1'($urandom);
      boot <= 16'($urandom);
      start(cfg);
      t0 = ticks;
      wr_reg(8'h00);
      rd_reg(`MWDT_CTRL_ADDR, cfg | 8'h20);
      wait_rst(30000);
      chk(near(ticks - t0, 32'h400 << i), 32'h1);
      rd_reg(`MWDT_CTRL_ADDR, 8'h80 | (cfg & 8'h5f));
      chk({16'h0, vec}, {16'h0, (flash ? boot : 16'h0)});
      sysrst();
      rd_reg(`MWDT_CTRL_ADDR, 8'h00);
    end
    // periodic clears keep the counter far from overflow
    start(8'h00);
    t0 = rst_seen;
    repeat (3) begin
      wait_ticks(700);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
    end
    chk(rst_seen, t0);
    sysrst();
    // suspend setting stops the watchdog at standby entry
    start(8'h08);
    halt <= 1'b1;
    rd_reg(`MWDT_CTRL_ADDR, 8'h08);
    chk({31'h0, rc_on}, 32'h1);
    halt <= 1'b0;
    wr_reg(8'h15);
    rd_reg(`MWDT_CTRL_ADDR, 8'h15);
    sysrst();
    // pause setting freezes the count and drops the oscillator unless forced
    start(8'h10);
    wait_ticks(300);
    halt <= 1'b1;
    repeat (20) @(posedge clk_in);
    chk(rc_on, 1'b0);
    force_on <= 1'b1;
    t0 = rst_seen;
    repeat (5) @(posedge clk_in);
    chk(rc_on, 1'b1);
    wait_ticks(1500);
    chk(rst_seen, t0);
    force_on <= 1'b0;
    halt <= 1'b0;
    // quick re-entry keeps the oscillator request up
    repeat (2) @(posedge clk_in);
    halt <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk({31'h0, rc_on}, 32'h1);
    halt <= 1'b0;
    wait_rst(20000);
    sysrst();
    // subclock loss forces a reset; let the oscillator settle first
    sub_en <= 1'b1;
    repeat (200) @(posedge clk_in);
    start(8'h40);
    t0 = rst_seen;
    repeat (100) @(posedge clk_in);
    chk(rst_seen, t0);
    if ($urandom_range(1, 0)) sub_en <= 1'b0;
    else hold <= 1'b1;
    wait_rst(60);
    rd_reg(`MWDT_CTRL_ADDR, 8'hc0);
    finish_test();
  end
endmodule // mcu_watchdog_timer_tb_top

`default_nettype wire

//--- test/mwdt_osc_model.sv
// oscillator model: low-speed rc and subclock sources seen by the watchdog
`timescale 1ns/100ps
`default_nettype none

module mwdt_osc_model #(
  parameter int RC_HALF_NS  = 23,
  parameter int SUB_HALF_NS = 31
) (
  input  wire logic        rc_on_in,
  input  wire logic        sub_on_in,
  output var  logic        rc_clk_out,
  output var  logic        sub_clk_out,
  output var  logic [31:0] rc_ticks_out
);
  // rc source toggles only while requested, then parks low
  initial begin
    rc_clk_out   = 1'b0;
    rc_ticks_out = 32'h0;
    forever begin
      #(RC_HALF_NS);
      if (rc_on_in || rc_clk_out) begin
        rc_clk_out = ~rc_clk_out;
        if (rc_clk_out) rc_ticks_out = rc_ticks_out + 32'h1;
      end
    end
  end

  // subclock runs only while enabled and not in hold
  initial begin
    sub_clk_out = 1'b0;
    forever begin
      #(SUB_HALF_NS);
      if (sub_on_in || sub_clk_out) sub_clk_out = ~sub_clk_out;
    end
  end
endmodule // mwdt_osc_model

`default_nettype wire

//--- verilog/mwdt_pin_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none

module mwdt_pin_sync (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic pin_in,
  output var  logic rise_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // ----------------------------------------------------------------------------
  // synchroniser chain; only s2 reads s1
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else if (ce_in) begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // filtered level follows once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      level_ff <= 1'b0;
      rise_out <= 1'b0;
    end else if (ce_in) begin
      if (s2_ff == s3_ff) begin
        level_ff <= s2_ff;
      end
      rise_out <= (s2_ff == s3_ff) && s2_ff && !level_ff;
    end
  end

endmodule // mwdt_pin_sync

`default_nettype wire

//--- verilog/mwdt_pkg.sv
// types and decode functions shared by the watchdog files
`default_nettype none
`include "mwdt_regs.svh"

package mwdt_pkg;

  typedef logic [16:0] mwdt_count_t;

  // decoded standby action
  typedef enum logic [1:0] {
    MWDT_SB_CONTINUE,
    MWDT_SB_STOP,
    MWDT_SB_HOLDCNT
  } mwdt_sb_act_t;

  // last count value before overflow for an overflow select code
  function automatic mwdt_count_t mwdt_ovf_limit(input logic [2:0] sel);
    mwdt_count_t base;
    base = `MWDT_OVF_BASE;
    return mwdt_count_t'(base << sel) - mwdt_count_t'(1);
  endfunction

  // standby field to action: 00 and 11 continue
  function automatic mwdt_sb_act_t mwdt_sb_decode(input logic [1:0] code);
    if (code == `MWDT_SB_SUSPEND) begin
      return MWDT_SB_STOP;
    end else if (code == `MWDT_SB_PAUSE) begin
      return MWDT_SB_HOLDCNT;
    end
    return MWDT_SB_CONTINUE;
  endfunction

endpackage

`default_nettype wire

//--- verilog/mwdt_regs.svh
// register map, field positions, reset values and timing counts of the watchdog
//
// How it works
// - control register ignores writes while running
// - only resets or suspend-standby stop the watchdog
// - running counter overflow issues watchdog reset
// - clear strobe zeroes counter; firmware repeats it
// - overflow sets sticky reset flag bit 7
// - restart at 0000H, or option address
// - pause setting freezes counter, stops RC oscillator
// - early standby re-entry may keep oscillator running
// - settings 0, 1 and 3 keep RC oscillator in HOLD when RC is the selected clock
// - force-on keeps RC oscillator running
// - subclock loss while running on the subclock forces watchdog reset
// - overflow select gives 1024 up to 131072
// - standby field: continue, suspend, pause, continue
// - clock select: 0 RC oscillator, 1 subclock
// - system reset clears all; watchdog reset keeps config
`ifndef MWDT_REGS_SVH
`define MWDT_REGS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define MWDT_CTRL_ADDR      16'hfe79
`define MWDT_CTRL_RST       8'h00
`define MWDT_BIT_FLAG       7
`define MWDT_BIT_CKSL       6
`define MWDT_BIT_RUN        5
`define MWDT_SB_HI          4
`define MWDT_SB_LO          3
`define MWDT_OV_HI          2
`define MWDT_OV_LO          0

// ----------------------------------------------------------------------------
// encodings and values
// ----------------------------------------------------------------------------
`define MWDT_SB_SUSPEND     2'h1
`define MWDT_SB_PAUSE       2'h2
`define MWDT_OVF_BASE       17'h00400
`define MWDT_RESET_VEC      16'h0000
`define MWDT_RC_SETTLE      3'h4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define MWDT_CLK_MHZ        250
`define MWDT_SUB_LOSS_NS    100000
`define MWDT_SUB_LOSS_CYC   ((`MWDT_SUB_LOSS_NS * `MWDT_CLK_MHZ) / 1000)

`endif

//--- verilog/mwdt_top.sv
// watchdog core: control register, 17-bit counter, standby and subclock-loss handling
`timescale 1ns/100ps
`default_nettype none
`include "mwdt_regs.svh"

module mwdt_top
  import mwdt_pkg::*;
#(
  parameter int SUB_LOSS_CYCLES = `MWDT_SUB_LOSS_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output var  logic [7:0]  reg_rdata_out,
  input  wire logic        clr_strobe_in,
  input  wire logic        halt_in,
  input  wire logic        hold_in,
  input  wire logic        rc_force_on_in,
  input  wire logic        sub_osc_enable_in,
  input  wire logic        rc_clk_in,
  input  wire logic        sub_clk_in,
  input  wire logic        flash_variant_in,
  input  wire logic [15:0] boot_addr_opt_in,
  output var  logic        wdt_reset_out,
  output var  logic        rc_osc_on_out,
  output var  logic [15:0] restart_addr_out
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic         wd_reset_flag_ff;
  logic         count_clock_select_ff;
  logic         run_enable_ff;
  logic [1:0]   standby_behaviour_ff;
  logic [2:0]   overflow_select_ff;
  mwdt_count_t  watchdog_counter_ff;
  logic         sb_prev_ff;
  logic [2:0]   rc_gap_ff;
  logic         rc_stop_ok_ff;
  logic         sb_keep_ff;
  logic [15:0]  loss_cnt_ff;

  logic         rc_rise;
  logic         sub_rise;
  logic         reg_hit;
  logic         wr_ctrl;
  logic         sb_now;
  logic         sb_entry;
  logic         sb_exit;
  mwdt_sb_act_t sb_act;
  logic         suspend_stop;
  logic         paused;
  logic         tick;
  logic         clr_hit;
  logic         ovf_hit;
  logic         loss_timeout;
  logic         sub_lost;
  logic         wd_fire;
  logic         stop_ok_now;
  logic         nxt_rc_on;
  logic [7:0]   ctrl_view;

  // ----------------------------------------------------------------------------
  // count clock inputs from pins
  // ----------------------------------------------------------------------------
  mwdt_pin_sync u_rc_sync (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .ce_in    (ce_in),
    .pin_in   (rc_clk_in),
    .rise_out (rc_rise)
  );

  mwdt_pin_sync u_sub_sync (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .ce_in    (ce_in),
    .pin_in   (sub_clk_in),
    .rise_out (sub_rise)
  );

  // ----------------------------------------------------------------------------
  // decode of bus, standby and count events
  // ----------------------------------------------------------------------------
  assign reg_hit      = (reg_addr_in == `MWDT_CTRL_ADDR);
  assign wr_ctrl      = ce_in && reg_wr_in && reg_hit && !run_enable_ff;
  assign sb_now       = halt_in || hold_in;
  assign sb_entry     = sb_now && !sb_prev_ff;
  assign sb_exit      = !sb_now && sb_prev_ff;
  assign sb_act       = mwdt_sb_decode(standby_behaviour_ff);
  assign suspend_stop = run_enable_ff && sb_entry && (sb_act == MWDT_SB_STOP);
  assign paused       = run_enable_ff && sb_now && (sb_act == MWDT_SB_HOLDCNT);
  assign tick         = count_clock_select_ff ? sub_rise : rc_rise;
  assign clr_hit      = run_enable_ff && clr_strobe_in;

  // overflow on the tick that would step past the selected count
  assign ovf_hit = run_enable_ff && !paused && tick && !clr_hit
                   && (watchdog_counter_ff == mwdt_ovf_limit(overflow_select_ff));

  // subclock gone: enable dropped, HOLD entered, or no edge for too long
  assign loss_timeout = (loss_cnt_ff == 16'(SUB_LOSS_CYCLES - 1));
  assign sub_lost     = run_enable_ff && count_clock_select_ff && !suspend_stop
                        && (!sub_osc_enable_in || hold_in || loss_timeout);
  assign wd_fire      = ovf_hit || sub_lost;

  // read view of the control register
  assign ctrl_view = {wd_reset_flag_ff, count_clock_select_ff, run_enable_ff,
                      standby_behaviour_ff, overflow_select_ff};

  // ----------------------------------------------------------------------------
  // control register: configuration fields
  // ----------------------------------------------------------------------------
  // kept through a watchdog reset, loaded only while stopped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_clock_select_ff <= 1'(`MWDT_CTRL_RST >> `MWDT_BIT_CKSL);
      standby_behaviour_ff  <= 2'h0;
      overflow_select_ff    <= 3'h0;
    end else if (wr_ctrl) begin
      count_clock_select_ff <= reg_wdata_in[`MWDT_BIT_CKSL];
      standby_behaviour_ff  <= reg_wdata_in[`MWDT_SB_HI:`MWDT_SB_LO];
      overflow_select_ff    <= reg_wdata_in[`MWDT_OV_HI:`MWDT_OV_LO];
    end
  end

  // ----------------------------------------------------------------------------
  // control register: run enable
  // ----------------------------------------------------------------------------
  // no write can stop it; overflow, loss or suspend entry clear it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_enable_ff <= 1'b0;
    end else if (ce_in) begin
      if (wd_fire || suspend_stop) begin
        run_enable_ff <= 1'b0;
      end else if (wr_ctrl) begin
        run_enable_ff <= reg_wdata_in[`MWDT_BIT_RUN];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control register: reset flag
  // ----------------------------------------------------------------------------
  // set by overflow or loss; set wins over a write in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wd_reset_flag_ff <= 1'b0;
    end else if (ce_in) begin
      if (wd_fire) begin
        wd_reset_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
        wd_reset_flag_ff <= reg_wdata_in[`MWDT_BIT_FLAG];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------------------
  // zero while stopped; cleared by strobe; frozen in pause standby
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      watchdog_counter_ff <= '0;
    end else if (ce_in) begin
      if (!run_enable_ff || clr_hit || wd_fire || suspend_stop) begin
        watchdog_counter_ff <= '0;
      end else if (tick && !paused) begin
        watchdog_counter_ff <= watchdog_counter_ff + mwdt_count_t'(1);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // standby tracking
  // ----------------------------------------------------------------------------
  // previous standby level for entry and exit detection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sb_prev_ff <= 1'b0;
    end else if (ce_in) begin
      sb_prev_ff <= sb_now;
    end
  end

  // RC periods elapsed since the last standby release, saturating at four
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rc_gap_ff <= `MWDT_RC_SETTLE;
    end else if (ce_in) begin
      if (sb_exit) begin
        rc_gap_ff <= 3'h0;
      end else if (!sb_now && rc_rise && (rc_gap_ff != `MWDT_RC_SETTLE)) begin
        rc_gap_ff <= rc_gap_ff + 3'h1;
      end
    end
  end

  // whether this standby was entered late enough to let the oscillator stop
  assign stop_ok_now = sb_entry ? (rc_gap_ff == `MWDT_RC_SETTLE) : rc_stop_ok_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rc_stop_ok_ff <= 1'b1;
    end else if (ce_in) begin
      rc_stop_ok_ff <= stop_ok_now;
    end
  end

  // suspend setting with the RC clock selected keeps the oscillator up for the rest of this standby
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sb_keep_ff <= 1'b0;
    end else if (ce_in) begin
      if (!sb_now) begin
        sb_keep_ff <= 1'b0;
      end else if (suspend_stop && !count_clock_select_ff) begin
        sb_keep_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // RC oscillator request
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_rc_on = 1'b0;
    if (rc_force_on_in) begin
      nxt_rc_on = 1'b1;
    end else if (run_enable_ff && !count_clock_select_ff && !paused) begin
      nxt_rc_on = 1'b1;
    end else if (sb_keep_ff || (suspend_stop && !count_clock_select_ff)) begin
      nxt_rc_on = 1'b1;
    end else if (sb_now && !stop_ok_now && rc_osc_on_out) begin
      nxt_rc_on = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rc_osc_on_out <= 1'b0;
    end else if (ce_in) begin
      rc_osc_on_out <= nxt_rc_on;
    end
  end

  // ----------------------------------------------------------------------------
  // subclock edge watchdog
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      loss_cnt_ff <= 16'h0000;
    end else if (ce_in) begin
      if (!run_enable_ff || !count_clock_select_ff || sub_rise) begin
        loss_cnt_ff <= 16'h0000;
      end else if (!loss_timeout) begin
        loss_cnt_ff <= loss_cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // reset request and restart address
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wdt_reset_out <= 1'b0;
    end else if (ce_in) begin
      wdt_reset_out <= wd_fire;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      restart_addr_out <= `MWDT_RESET_VEC;
    end else if (ce_in && wd_fire) begin
      restart_addr_out <= flash_variant_in ? boot_addr_opt_in : `MWDT_RESET_VEC;
    end
  end

  // ----------------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------------
  // data stand for exactly one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rdata_out <= (reg_rd_in && reg_hit) ? ctrl_view : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking mwdt_cb @(posedge clk_in);
  endclocking

  default disable iff (srst_in);

  a_write_locked:
    assert property (ce_in && run_enable_ff && reg_wr_in && reg_hit
                     |=> $stable(overflow_select_ff) && $stable(standby_behaviour_ff)
                         && $stable(count_clock_select_ff))
    else $error("control register changed while running");

  a_run_holds:
    assert property (ce_in && run_enable_ff && !wd_fire && !suspend_stop
                     |=> run_enable_ff)
    else $error("running watchdog stopped without cause");

  a_overflow_fires:
    assert property (ce_in && run_enable_ff && tick && !paused && !clr_hit
                     && watchdog_counter_ff == mwdt_ovf_limit(overflow_select_ff)
                     |=> wdt_reset_out && !run_enable_ff && watchdog_counter_ff == '0)
    else $error("overflow did not raise watchdog reset");

  a_clear_zeroes:
    assert property (ce_in && run_enable_ff && clr_strobe_in
                     |=> watchdog_counter_ff == '0 ##1 watchdog_counter_ff <= mwdt_count_t'(1))
    else $error("clear strobe did not zero the counter");

  a_flag_with_reset:
    assert property ($rose(wdt_reset_out) |-> wd_reset_flag_ff)
    else $error("reset flag not set with watchdog reset");

  a_restart_addr:
    assert property (ce_in && wd_fire
                     |=> restart_addr_out == ($past(flash_variant_in) ? $past(boot_addr_opt_in)
                                                                      : `MWDT_RESET_VEC))
    else $error("restart address wrong after watchdog reset");

  a_pause_freezes:
    assert property (ce_in && paused && !clr_hit && !wd_fire |=> $stable(watchdog_counter_ff))
    else $error("counter moved during pause standby");

  a_force_on:
    assert property (ce_in && rc_force_on_in |=> rc_osc_on_out)
    else $error("oscillator off while forced on");

  a_sub_loss:
    assert property (ce_in && run_enable_ff && count_clock_select_ff && !sub_osc_enable_in && !suspend_stop
                     |=> wdt_reset_out && wd_reset_flag_ff)
    else $error("subclock loss did not force watchdog reset");

  a_count_bound:
    assert property (watchdog_counter_ff <= mwdt_ovf_limit(overflow_select_ff))
    else $error("counter passed selected overflow count");

  a_early_reentry:
    assert property (ce_in && sb_entry && rc_gap_ff != `MWDT_RC_SETTLE && rc_osc_on_out
                     |=> rc_osc_on_out)
    else $error("oscillator stopped on early standby re-entry");

endmodule // mwdt_top

`default_nettype wire
